// ==== core/aaat_access_timer.sv ====
// Purpose: counts out one bus transfer's duration in system clock cycles
// Assumes: start pulses only while idle
// Notes:   gnss done comes from the core clock crossing, already synchronised
`timescale 1ns/1ps
`default_nettype none
module aaat_access_timer (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 start,
    input  wire aaat_pkg::aaat_req_s  req,
    input  wire aaat_pkg::aaat_cfg_s  cfg,
    input  wire logic                 ready_in,
    input  wire logic                 gnss_done,
    output logic                      busy,
    output logic                      done
);
    logic [3:0]  region_nib;
    logic [5:0]  ext_len;
    logic [5:0]  fixed_len;
    logic [3:0]  ext_count;
    logic        is_prom;
    logic        is_io;
    logic        is_ram;
    logic        is_gnss;
    logic        narrow;
    logic        rmw;
    logic        use_ready;
    logic        is_ext;
    logic [5:0]  cyc_q;
    logic [5:0]  cyc_d;
    logic [3:0]  acc_q;
    logic [3:0]  acc_d;
    logic [5:0]  len_q;
    logic        ext_q;
    logic        gnss_q;
    logic        rdy_q;
    logic        busy_q;
    logic        last_cyc;
    logic        cycle_end;
    logic        finish;

    assign region_nib = req.addr[31:28];
    assign is_prom    = region_nib <= aaat_pkg::NIB_PROM_HI;
    assign is_io      = !is_prom && region_nib <= aaat_pkg::NIB_IO_HI;
    assign is_ram     = !is_prom && !is_io && region_nib <= aaat_pkg::NIB_RAM_HI;
    assign is_gnss    = region_nib == aaat_pkg::NIB_GNSS;
    assign is_ext     = is_prom || is_io || is_ram;
    // wait states plus two per external access
    assign ext_len    = aaat_pkg::EXT_BASE_CYCLES + (is_prom ? {1'b0, cfg.prom_ws} :
                        is_io ? {2'b00, cfg.io_ws} : {3'b000, cfg.ram_ws});
    assign use_ready  = is_prom ? cfg.prom_ready_en : (is_io ? cfg.io_ready_en : 1'b0);
    assign narrow     = is_prom ? !cfg.prom_wide : !cfg.ram_wide;
    assign rmw        = is_ram && cfg.ecc_on && req.write && req.size != aaat_pkg::SIZE_WORD;
    // io always one external access
    assign ext_count  = is_io ? 4'h1 :
                        rmw ? (narrow ? aaat_pkg::RMW8_ACCESSES : aaat_pkg::RMW32_ACCESSES) :
                        (cfg.ecc_on && narrow && req.size == aaat_pkg::SIZE_WORD
                         && (is_ram || !req.write)) ? aaat_pkg::ECC8_ACCESSES : 4'h1;
    assign fixed_len  = region_nib == aaat_pkg::NIB_APB ? aaat_pkg::APB_CYCLES :
                        region_nib == aaat_pkg::NIB_FFT ?
                        (req.addr[27:0] == aaat_pkg::FFT_CTRL_OFFSET ? aaat_pkg::FFT_CTRL_CYCLES
                         : aaat_pkg::FFT_MEM_CYCLES) : aaat_pkg::DEBUG_CYCLES;

    assign last_cyc   = cyc_q >= len_q - 6'h01;
    assign cycle_end  = last_cyc && (!ext_q || !rdy_q || ready_in);
    // gnss length set by the crossing handshake
    assign finish     = busy_q && (gnss_q ? gnss_done : (cycle_end && (!ext_q || acc_q <= 4'h1)));
    assign cyc_d      = start ? 6'h00 : (cycle_end ? 6'h00 : cyc_q + 6'h01);
    assign acc_d      = start ? ext_count : (cycle_end ? acc_q - 4'h1 : acc_q);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_q  <= 6'h00;
            acc_q  <= 4'h0;
            len_q  <= 6'h01;
            ext_q  <= 1'b0;
            gnss_q <= 1'b0;
            rdy_q  <= 1'b0;
            busy_q <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= finish;
            if (start) begin
                busy_q <= 1'b1;
                len_q  <= is_ext ? ext_len : fixed_len;
                ext_q  <= is_ext;
                gnss_q <= is_gnss;
                rdy_q  <= use_ready;
            end else if (finish) begin
                busy_q <= 1'b0;
            end
            if (busy_q || start) begin
                cyc_q <= cyc_d;
                acc_q <= acc_d;
            end
        end
    end
    assign busy = busy_q;
endmodule
`default_nettype wire

// ==== core/aaat_arbiter.sv ====
// Purpose: fixed priority bus arbiter with burst lock and access timing
// Assumes: one system clock, bus ready pin asynchronous
// Notes:   transfer done pulses one cycle after the last timed cycle
`timescale 1ns/1ps
`default_nettype none
module aaat_arbiter #(
    parameter int NUM_M = aaat_pkg::NUM_MASTERS
) (
    input  wire logic                 REF_CLK,
    input  wire logic                 ARST_N,
    input  wire logic [NUM_M-1:0]     REQ,
    input  wire aaat_pkg::aaat_req_s  REQ_INFO [NUM_M],
    input  wire aaat_pkg::aaat_cfg_s  CFG,
    input  wire logic                 BUS_READY_IN_N,
    input  wire logic                 GNSS_ACK,
    output logic [NUM_M-1:0]          GRANT,
    output logic [2:0]                OWNER,
    output logic                      BEAT_DONE,
    output logic                      BURST_ACTIVE
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_GAP  = 3'b100
    } aaat_state_e;

    aaat_state_e          state_q;
    aaat_state_e          state_d;
    logic [2:0]           owner_q;
    logic [2:0]           winner;
    logic                 any_req;
    logic [3:0]           beats_q;
    logic                 start;
    logic                 t_done;
    logic                 rdy_s1_q;
    logic                 rdy_s2_q;
    logic                 gack_s1_q;
    logic                 gack_s2_q;
    logic                 gack_s3_q;
    logic                 gnss_done;
    logic                 burst_more;
    aaat_pkg::aaat_req_s  cur_req;
    aaat_pkg::aaat_req_s  req_q;
    logic [NUM_M-1:0]     grant_d;

    // highest index wins
    always_comb begin
        winner = 3'h0;
        for (int i = 0; i < NUM_M; i++) begin
            if (REQ[i]) begin
                winner = 3'(i);
            end
        end
    end
    assign any_req    = |REQ;
    // owner kept for all beats, no pre-emption
    assign burst_more = beats_q > 4'h1;
    assign cur_req    = REQ_INFO[owner_q];
    assign start      = state_q == ST_GAP;
    // gnss ack is a level toggle from the core domain
    assign gnss_done  = gack_s2_q ^ gack_s3_q;
    // straight off the timer's done flop: a master sees it before re-arbitration
    assign BEAT_DONE  = t_done;

    generate
        for (genvar g = 0; g < NUM_M; g++) begin : g_grant
            assign grant_d[g] = (state_d != ST_IDLE) && (state_d == ST_XFER ? owner_q :
                                (burst_more && state_q == ST_XFER ? owner_q : winner)) == 3'(g);
        end
    endgenerate

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (any_req) begin
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                state_d = ST_XFER;
            end
            ST_XFER: begin
                if (t_done) begin
                    state_d = (burst_more || any_req) ? ST_GAP : ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdy_s1_q  <= 1'b0;
            rdy_s2_q  <= 1'b0;
            gack_s1_q <= 1'b0;
            gack_s2_q <= 1'b0;
            gack_s3_q <= 1'b0;
        end else begin
            rdy_s1_q  <= !BUS_READY_IN_N;
            rdy_s2_q  <= rdy_s1_q;
            gack_s1_q <= GNSS_ACK;
            gack_s2_q <= gack_s1_q;
            gack_s3_q <= gack_s2_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q      <= ST_IDLE;
            owner_q      <= 3'h0;
            beats_q      <= 4'h0;
            req_q        <= '0;
            GRANT        <= '0;
            OWNER        <= 3'h0;
            BURST_ACTIVE <= 1'b0;
        end else begin
            state_q   <= state_d;
            GRANT     <= grant_d;
            if ((state_q == ST_IDLE && any_req) || (state_q == ST_XFER && t_done)) begin
                if (burst_more && state_q == ST_XFER) begin
                    beats_q <= beats_q - 4'h1;
                    req_q   <= cur_req;
                end else begin
                    owner_q <= winner;
                    beats_q <= REQ_INFO[winner].beats;
                    req_q   <= REQ_INFO[winner];
                end
            end
            // owner moves with the grant, so the two never disagree
            OWNER        <= ((state_q == ST_IDLE && any_req) || (state_q == ST_XFER && t_done && !burst_more)) ?
                            winner : owner_q;
            BURST_ACTIVE <= state_d != ST_IDLE && beats_q > 4'h1;
        end
    end

    // too little to gain by splitting the timer per region
    aaat_access_timer u_timer (
        .clk       (REF_CLK),
        .arst_n    (ARST_N),
        .start     (start),
        .req       (req_q),
        .cfg       (CFG),
        .ready_in  (rdy_s2_q),
        .gnss_done (gnss_done),
        .busy      (),
        .done      (t_done)
    );
endmodule
`default_nettype wire

// ==== core/aaat_pkg.sv ====
// Purpose: shared constants and types for the bus arbiter and access timer
// Assumes: seven masters, fixed priority, system clock only
// Notes:   region codes come from the top address nibble
package aaat_pkg;
    localparam int NUM_MASTERS      = 7;
    localparam int MASTER_IDX_W     = 3;
    // master indices, higher index wins
    localparam logic [2:0] M_PROC   = 3'h0;
    localparam logic [2:0] M_CRC    = 3'h1;
    localparam logic [2:0] M_SPW    = 3'h2;
    localparam logic [2:0] M_UART   = 3'h3;
    localparam logic [2:0] M_GNSS   = 3'h4;
    localparam logic [2:0] M_MIL    = 3'h5;
    localparam logic [2:0] M_DEBUG  = 3'h6;
    // region address nibble upper bounds and codes
    localparam logic [3:0] NIB_PROM_HI  = 4'h1;
    localparam logic [3:0] NIB_IO_HI    = 4'h3;
    localparam logic [3:0] NIB_RAM_HI   = 4'h7;
    localparam logic [3:0] NIB_APB      = 4'h8;
    localparam logic [3:0] NIB_DEBUG    = 4'h9;
    localparam logic [3:0] NIB_GNSS     = 4'hA;
    localparam logic [3:0] NIB_FFT      = 4'hB;
    // fft control register offset inside its region
    localparam logic [27:0] FFT_CTRL_OFFSET = 28'h0000000;
    // timing
    localparam logic [5:0] EXT_BASE_CYCLES  = 6'h02;
    localparam logic [4:0] PROM_WS_MAX      = 5'h1E;
    localparam logic [3:0] IO_WS_MAX        = 4'hF;
    localparam logic [2:0] RAM_WS_MAX       = 3'h4;
    localparam logic [5:0] APB_CYCLES       = 6'h02;
    localparam logic [5:0] FFT_MEM_CYCLES   = 6'h02;
    localparam logic [5:0] FFT_CTRL_CYCLES  = 6'h01;
    localparam logic [5:0] DEBUG_CYCLES     = 6'h02;
    localparam logic [3:0] ECC8_ACCESSES    = 4'h5;
    localparam logic [3:0] RMW8_ACCESSES    = 4'hA;
    localparam logic [3:0] RMW32_ACCESSES   = 4'h2;
    // size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [3:0] {
        RG_PROM  = 4'h0,
        RG_IO    = 4'h1,
        RG_RAM   = 4'h2,
        RG_FIX   = 4'h3,
        RG_GNSS  = 4'h4,
        RG_NONE  = 4'h5
    } aaat_region_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  size;
        logic        write;
        logic [3:0]  beats;
    } aaat_req_s;

    typedef struct packed {
        logic [4:0] prom_ws;
        logic [3:0] io_ws;
        logic [2:0] ram_ws;
        logic       prom_wide;
        logic       ram_wide;
        logic       ecc_on;
        logic       prom_ready_en;
        logic       io_ready_en;
    } aaat_cfg_s;
endpackage

// ==== testbench/aaat_arbiter_chk.sv ====
// Purpose: port-level checks for the fixed priority arbiter
// Assumes: one clock domain, async active-low reset
// Notes:   exact figures only for fixed-length regions; variable ones go to the bench
`timescale 1ns/1ps
`default_nettype none
module aaat_arbiter_chk #(
    parameter int NUM_M = aaat_pkg::NUM_MASTERS
) (
    input wire logic                REF_CLK,
    input wire logic                ARST_N,
    input wire logic [NUM_M-1:0]    REQ,
    input wire aaat_pkg::aaat_req_s REQ_INFO [NUM_M],
    input wire aaat_pkg::aaat_cfg_s CFG,
    input wire logic                BUS_READY_IN_N,
    input wire logic                GNSS_ACK,
    input wire logic [NUM_M-1:0]    GRANT,
    input wire logic [2:0]          OWNER,
    input wire logic                BEAT_DONE,
    input wire logic                BURST_ACTIVE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    function automatic logic [2:0] top_of(input logic [NUM_M-1:0] r);
        top_of = 3'h0;
        for (int i = 0; i < NUM_M; i++) if (r[i]) top_of = 3'(i);
    endfunction
    property p_onehot; $onehot0(GRANT); endproperty
    a_onehot: assert property (p_onehot) else $error("grant not one-hot");
    property p_owner; GRANT != '0 |-> GRANT[OWNER]; endproperty
    a_owner: assert property (p_owner) else $error("owner disagrees with grant");
    property p_prio; GRANT != '0 && !$stable(GRANT) |-> OWNER == top_of($past(REQ)); endproperty
    a_prio: assert property (p_prio) else $error("grant not to top requester");
    property p_lock; BURST_ACTIVE |=> $stable(GRANT); endproperty
    a_lock: assert property (p_lock) else $error("burst pre-empted");
    property p_owned; BEAT_DONE |-> GRANT != '0; endproperty
    a_owned: assert property (p_owned) else $error("beat done without grant");
    property p_serve; REQ != '0 && GRANT == '0 |-> ##[1:2] GRANT != '0; endproperty
    a_serve: assert property (p_serve) else $error("idle bus not granted");
    property p_apb;
        $rose(GRANT != '0) && REQ_INFO[OWNER].addr[31:28] == aaat_pkg::NIB_APB |-> ##3 BEAT_DONE;
    endproperty
    a_apb: assert property (p_apb) else $error("peripheral access not two cycles");
    property p_fftc;
        $rose(GRANT != '0) && REQ_INFO[OWNER].addr == {aaat_pkg::NIB_FFT, aaat_pkg::FFT_CTRL_OFFSET} |-> ##2 BEAT_DONE;
    endproperty
    a_fftc: assert property (p_fftc) else $error("transform control access not one cycle");
    property p_min; $rose(GRANT != '0) |-> !BEAT_DONE [*2]; endproperty
    a_min: assert property (p_min) else $error("beat shorter than one cycle access");
    c_burst: cover property (BURST_ACTIVE ##1 BEAT_DONE);
    c_contend: cover property ($countones(REQ) > 1 && BEAT_DONE);
    c_gnss: cover property ($changed(GNSS_ACK) ##[1:8] BEAT_DONE);
endmodule
bind aaat_arbiter aaat_arbiter_chk #(.NUM_M(NUM_M)) u_aaat_arbiter_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .REQ(REQ), .REQ_INFO(REQ_INFO), .CFG(CFG), .BUS_READY_IN_N(BUS_READY_IN_N), .GNSS_ACK(GNSS_ACK),
    .GRANT(GRANT), .OWNER(OWNER), .BEAT_DONE(BEAT_DONE), .BURST_ACTIVE(BURST_ACTIVE));
`default_nettype wire

// ==== testbench/aaat_arbiter_tb_top.sv ====
// Purpose: self-checking bench for arbitration order and access lengths
// Assumes: one request per master held until its last beat
// Notes:   duration checked on first beat only; 0 in a note skips it
`timescale 1ns/1ps
`default_nettype none
module aaat_arbiter_tb_top;
    localparam int NM = aaat_pkg::NUM_MASTERS;
    logic REF_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic slow = 1'b0;
    logic [NM-1:0] req = '0;
    aaat_pkg::aaat_req_s info [NM];
    aaat_pkg::aaat_cfg_s cfg = '0;
    logic ready_n, ack, beat_done, burst;
    logic [NM-1:0] grant, g_last = '0;
    logic [2:0] owner;
    int fail_count = 0, n_compared = 0, cyc = 0, cnt = 0, m, d;
    int q_own [$], q_dur [$];
    int nibs [7] = '{0, 2, 4, 8, 9, 11, 10};
    int ms [6] = '{0, 2, 3, 1, 5, 4};
    int bs [6] = '{2, 2, 1, 1, 1, 1};
    always #2.5 REF_CLK = ~REF_CLK;
    aaat_arbiter u_aaat_arbiter (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .REQ(req), .REQ_INFO(info), .CFG(cfg),
        .BUS_READY_IN_N(ready_n), .GNSS_ACK(ack), .GRANT(grant), .OWNER(owner), .BEAT_DONE(beat_done),
        .BURST_ACTIVE(burst));
    aaat_slave_model u_aaat_slave_model (.clk(REF_CLK), .arst_n(ARST_N), .grant(grant), .info(info[owner]),
        .slow(slow), .ready_n(ready_n), .ack(ack));
    task automatic report(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask
    task automatic cmp_owner(input int e, input logic [2:0] g);
        report("owner", e, {29'h0, g});
    endtask
    task automatic cmp_dur(input int e, input int g);
        report("duration", e, g);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic int exp_len(input aaat_pkg::aaat_req_s r);
        logic w;
        w = r.size == aaat_pkg::SIZE_WORD;
        case (r.addr[31:28])
            4'h0, 4'h1: return (!cfg.prom_wide && cfg.ecc_on && w ? 5 : 1) * (2 + cfg.prom_ws);
            4'h2, 4'h3: return 2 + cfg.io_ws;
            4'h4, 4'h5, 4'h6, 4'h7: return (!cfg.ecc_on ? 1 : (!w && r.write) ? (cfg.ram_wide ? 2 : 10)
                : (!cfg.ram_wide && w) ? 5 : 1) * (2 + cfg.ram_ws);
            4'hA: return 0;
            4'hB: return r.addr[27:0] == 28'h0 ? 1 : 2;
            default: return 2;
        endcase
    endfunction
    task automatic note(input int o, input int nb, input int dl);
        for (int i = 0; i < nb; i++) begin
            q_own.push_back(o);
            q_dur.push_back(i == 0 && dl != 0 ? dl + 1 : 0);
        end
    endtask
    task automatic xfer(input int o, input int nb);
        int k = 0, w = 0;
        @(posedge REF_CLK);
        #1 req[o] = 1'b1;
        while (k < nb && w < 4000) begin
            @(posedge REF_CLK);
            #1 w++;
            if (beat_done === 1'b1 && owner === 3'(o)) k++;
        end
        req[o] = 1'b0;
    endtask
    always @(negedge REF_CLK) if (ARST_N) begin
        if (grant !== g_last && grant != '0) cnt = 0;
        else cnt++;
        g_last = grant;
        if (beat_done === 1'b1) begin
            if (q_own.size() == 0) report("unexpected beat", 0, 1);
            else begin
                cmp_owner(q_own.pop_front(), owner);
                d = q_dur.pop_front();
                if (d != 0) cmp_dur(d, cnt);
            end
        end
    end
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        foreach (info[i]) info[i] = '0;
        void'($urandom(27));
        repeat (4) @(posedge REF_CLK);
        #1 ARST_N = 1'b1;
        repeat (40) begin
            m = $urandom % NM;
            cfg = $bits(cfg)'($urandom);
            cfg.prom_ws = 5'($urandom % 31);
            cfg.io_ws = 4'($urandom % 16);
            cfg.ram_ws = 3'($urandom % 5);
            {cfg.prom_ready_en, cfg.io_ready_en} = 2'h0;
            // narrow memories only with ecc: plain narrow splits are not specified
            if (!cfg.ecc_on) {cfg.prom_wide, cfg.ram_wide} = 2'h3;
            info[m].addr = {4'(nibs[$urandom % 7]), 26'($urandom), 2'h0};
            if ($urandom % 2) info[m].addr[27:0] = 28'h0;
            info[m].size = info[m].addr[31:28] inside {[4'h4:4'h7]} ? 2'($urandom % 3) : aaat_pkg::SIZE_WORD;
            info[m].write = info[m].addr[31:28] > 4'h1 && $urandom % 2;
            info[m].beats = 4'h1;
            note(m, 1, exp_len(info[m]));
            xfer(m, 1);
        end
        for (int i = 0; i < NM; i++) info[i] = '{32'h80000010, aaat_pkg::SIZE_WORD, 1'b0, 4'h1};
        for (int i = NM - 1; i >= 0; i--) note(i, 1, 2);
        for (int i = 0; i < NM; i++) fork
            automatic int j = i;
            xfer(j, 1);
        join_none
        wait fork;
        info[0] = '{32'h40000100, aaat_pkg::SIZE_WORD, 1'b0, 4'h8};
        note(0, 8, exp_len(info[0]));
        note(6, 1, 0);
        fork
            xfer(0, 8);
            begin
                repeat (4) @(posedge REF_CLK);
                xfer(6, 1);
            end
        join
        for (int i = 0; i < 6; i++) begin
            info[ms[i]] = '{32'h40000200, aaat_pkg::SIZE_WORD, 1'b1, 4'(bs[i])};
            note(ms[i], bs[i], exp_len(info[ms[i]]));
            xfer(ms[i], bs[i]);
        end
        slow = 1'b1;
        cfg.io_ready_en = 1'b1;
        info[3] = '{32'h20000000, aaat_pkg::SIZE_WORD, 1'b0, 4'h1};
        note(3, 1, 0);
        xfer(3, 1);
        // let the watcher take the last note off before counting leftovers
        repeat (2) @(posedge REF_CLK);
        report("pending notes", 0, q_own.size());
        complete_run();
    end
endmodule
`default_nettype wire

// ==== testbench/aaat_slave_model.sv ====
// Purpose: far-side slaves: core-domain ack toggle and external ready pin
// Assumes: one transfer per grant change
// Notes:   slow mode holds ready off to stretch external accesses
`timescale 1ns/1ps
`default_nettype none
module aaat_slave_model #(
    parameter int ACK_DLY = 6,
    parameter int STALL   = 3
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [6:0]          grant,
    input  wire aaat_pkg::aaat_req_s info,
    input  wire logic                slow,
    output logic                     ready_n,
    output logic                     ack
);
    logic [6:0] g_q;
    int         cnt_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            g_q <= '0;
            cnt_q <= 0;
            ack <= 1'b0;
        end else begin
            g_q <= grant;
            cnt_q <= (grant != g_q) ? 0 : cnt_q + 1;
            // crossing latency stands in for an unknown clock ratio
            if (cnt_q == ACK_DLY && grant != '0 && info.addr[31:28] == aaat_pkg::NIB_GNSS) ack <= ~ack;
        end
    end
    assign ready_n = slow && cnt_q < STALL;
endmodule
`default_nettype wire
